//--- logic/chan_cfg_defs.svh
// Register offsets, field positions, reset values and codes for the channel config block
`ifndef CHAN_CFG_DEFS_SVH
`define CHAN_CFG_DEFS_SVH

// Register byte offsets
`define OFS_CFG          8'h00
`define OFS_LIMIT        8'h04
`define OFS_STATUS       8'h08
`define OFS_CLEAR        8'h0c
`define OFS_ENABLE       8'h10
`define OFS_STATE        8'h14

// Configuration descriptor fields
`define CFG_PROTO_LSB    12
`define CFG_PROTO_MSB    14
`define CFG_SEL_LSB      10
`define CFG_SEL_MSB      11
`define CFG_FCS_BIT      9
`define CFG_MSK_THR      8
`define CFG_MSK_UP       7
`define CFG_MSK_DN       6
`define CFG_MSK_DUP      5
`define CFG_MSK_LINE     4
`define CFG_MSK_MSG      3
`define CFG_MSK_EOM      2
`define CFG_MSK_FIFO     1
`define CFG_RST          32'h0000_0000
`define CFG_WMASK        32'h0000_7ffe

// Length descriptor: first limit low half, second limit high half
`define LIM_FIRST_LSB    0
`define LIM_SECOND_LSB   16
`define LIMIT_RST        32'h0fff_0fff

// Status, clear and enable bit positions
`define ST_THR           0
`define ST_UP            1
`define ST_DN            2
`define ST_DUP           3
`define ST_LINE          4
`define ST_MSG           5
`define ST_EOM           6
`define ST_FIFO          7
`define ST_OWN           8
`define ST_W             9
`define ENABLE_RST       9'h000

// Protocol codes
`define PROTO_TRANSP     3'h0
`define PROTO_SIGNAL     3'h1
`define PROTO_FCS16      3'h2
`define PROTO_FCS32      3'h3

// Length limit select codes
`define SEL_OFF          2'h0
`define SEL_FIRST        2'h1
`define SEL_SECOND       2'h2

// Messages below this byte count are too short
`define SHORT_MIN_BYTES  16'h0004

// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

//--- logic/chan_cfg_pkg.sv
// Types shared by the channel config block
package chan_cfg_pkg;

   typedef logic [15:0] len_t;

   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } axil_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_s;

   typedef struct packed {
      logic        thresh_cross;
      logic        count_up;
      logic        count_down;
      logic        abort_change;
      logic        idle_change;
      logic        fcs_error;
      logic        align_error;
      logic        abort;
      logic        rx_end;
      logic        tx_end;
      logic        tx_underflow;
      logic        rx_overflow;
      logic        rx_own_missing;
      logic        tx_own_missing;
      logic        rx_msg_done;
      len_t        rx_msg_len;
      logic [31:0] rx_msg_sig;
   } chan_ev_s;

   typedef struct packed {
      logic [2:0]  protocol;
      logic        signalling_mode;
      logic        crc32_sel;
      logic        rx_store_fcs;
      logic        tx_append_fcs;
      logic        short_check_en;
      logic        len_check_en;
      len_t        len_limit;
      logic        rx_discard;
      logic        rx_len_error;
      logic        rx_short_error;
   } chan_ctrl_s;

endpackage

//--- logic/sticky_bank.sv
// Bank of sticky event flags where a set beats a clear in the same cycle
`timescale 1ns/10ps
module sticky_bank #(
   parameter int W = 8
) (
   input  wire logic         ref_clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] flags_q
);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~clr) | set;
      end
   end

   a_set_wins: assert property (@(posedge ref_clk) disable iff (srst)
      |set |=> ((flags_q & $past(set)) == $past(set)))
      else $error("sticky flag lost its set");

endmodule

//--- logic/dup_filter.sv
// Remembers the last received message and flags an identical successor
`timescale 1ns/10ps
module dup_filter (
   input  wire logic                ref_clk,
   input  wire logic                srst,
   input  wire logic                enable,
   input  wire logic                msg_done,
   input  wire chan_cfg_pkg::len_t  msg_len,
   input  wire logic [31:0]         msg_sig,
   output logic                     match
);

   logic                last_valid_q;
   chan_cfg_pkg::len_t  last_len_q;
   logic [31:0]         last_sig_q;

   // Outside the filtering mode history is dropped, so a stale message cannot match later
   always_ff @(posedge ref_clk) begin
      if (srst || !enable) begin
         last_valid_q <= 1'b0;
         last_len_q   <= 16'h0000;
         last_sig_q   <= 32'h0000_0000;
      end else if (msg_done) begin
         last_valid_q <= 1'b1;
         last_len_q   <= msg_len;
         last_sig_q   <= msg_sig;
      end
   end

   assign match = enable && msg_done && last_valid_q &&
                  (last_len_q == msg_len) && (last_sig_q == msg_sig);

endmodule

//--- logic/channel_event_mask_config.sv
// Channel configuration, event masking and interrupt status with an AXI4-Lite slave
//
// Operation
// - Select value 2 checks length against second limit; value 3 reserved.
// - FCS bit clear: receiver drops check sequence, transmitter appends it.
// - FCS bit set: receiver stores check sequence, transmitter sends none.
// - Without check sequence, short-message detection off; any byte count accepted.
// - Signalling mode: mask bit 8 clear reports error threshold crossing.
// - Signalling mode: mask bit 7 clear reports each error count increment.
// - Signalling mode: mask bit 6 clear reports each error count decrement.
// - Signalling mode: duplicate second message always discarded; reported if bit 5 clear.
// - Mask bit 4 clear reports abort change, idle change, short message.
// - Mask bit 3 clear reports long, check-sequence, alignment and abort errors.
// - Long, check and alignment reports silenced only when bits 3 and 2 set.
// - Mask bit 2 clear reports end of message, both directions.
// - Mask bit 1 clear reports buffer underflow or overflow.
// - Mask bit 1 clear reports missing descriptor ownership, both directions.
// - Protocol field: 0 transparent, 1 signalling, 2 FCS16, 3 FCS32, rest reserved.
// - Select 0 disables length check; select 1 uses the first limit.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "chan_cfg_defs.svh"
module channel_event_mask_config (
   input  wire logic                    ref_clk,
   input  wire logic                    srst,
   input  wire chan_cfg_pkg::axil_req_s axil_req,
   output chan_cfg_pkg::axil_rsp_s      axil_rsp,
   input  wire chan_cfg_pkg::chan_ev_s  chan_ev,
   output chan_cfg_pkg::chan_ctrl_s     chan_ctrl,
   output logic                         irq
);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and bus state

   chan_cfg_pkg::axil_rsp_s  rsp_q;
   chan_cfg_pkg::chan_ctrl_s ctrl_q;
   logic [31:0]              cfg_q;
   logic [31:0]              limit_q;
   logic [`ST_W-1:0]         enable_q;
   logic [`ST_W-1:0]         status_q;
   logic [15:0]              discard_cnt_q;
   logic                     irq_q;

   logic                     aw_hold_q;
   logic [31:0]              aw_addr_q;
   logic                     w_hold_q;
   logic [31:0]              w_data_q;
   logic [3:0]               w_strb_q;

   logic                     do_write;
   logic                     wr_hit;
   logic                     rd_hit;
   logic [31:0]              rd_data;
   logic [`ST_W-1:0]         clr_bits;
   logic [`ST_W-1:0]         set_bits;
   logic [31:0]              clr_word;
   logic [31:0]              en_word;

   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [31:0] a);
      return (a[31:8] == 24'h00_0000) && (a[1:0] == 2'h0) &&
             ((a[7:0] == `OFS_CFG)    || (a[7:0] == `OFS_LIMIT)  ||
              (a[7:0] == `OFS_STATUS) || (a[7:0] == `OFS_CLEAR)  ||
              (a[7:0] == `OFS_ENABLE) || (a[7:0] == `OFS_STATE));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Configuration field decode

   logic [2:0]  proto;
   logic [1:0]  len_sel;
   logic        fcs_mode;
   logic        sig_mode;
   logic        msk_thr;
   logic        msk_up;
   logic        msk_dn;
   logic        msk_dup;
   logic        msk_line;
   logic        msk_msg;
   logic        msk_eom;
   logic        msk_fifo;
   logic        len_chk;
   chan_cfg_pkg::len_t len_lim;

   assign proto    = cfg_q[`CFG_PROTO_MSB:`CFG_PROTO_LSB];
   assign len_sel  = cfg_q[`CFG_SEL_MSB:`CFG_SEL_LSB];
   assign fcs_mode = cfg_q[`CFG_FCS_BIT];
   assign msk_thr  = cfg_q[`CFG_MSK_THR];
   assign msk_up   = cfg_q[`CFG_MSK_UP];
   assign msk_dn   = cfg_q[`CFG_MSK_DN];
   assign msk_dup  = cfg_q[`CFG_MSK_DUP];
   assign msk_line = cfg_q[`CFG_MSK_LINE];
   assign msk_msg  = cfg_q[`CFG_MSK_MSG];
   assign msk_eom  = cfg_q[`CFG_MSK_EOM];
   assign msk_fifo = cfg_q[`CFG_MSK_FIFO];

   // Reserved protocol codes get no signalling behaviour
   assign sig_mode = (proto == `PROTO_SIGNAL);

   // Reserved select value 3 behaves as no check rather than an undefined limit
   assign len_chk = (len_sel == `SEL_FIRST) || (len_sel == `SEL_SECOND);
   always_comb begin
      case (len_sel)
         `SEL_FIRST:  len_lim = limit_q[`LIM_FIRST_LSB +: 16];
         `SEL_SECOND: len_lim = limit_q[`LIM_SECOND_LSB +: 16];
         default:     len_lim = 16'hffff;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Detection, independent of any mask

   logic dup_match;
   logic dup_det;
   logic long_det;
   logic short_det;

   dup_filter u_dup (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .enable   (sig_mode),
      .msg_done (chan_ev.rx_msg_done),
      .msg_len  (chan_ev.rx_msg_len),
      .msg_sig  (chan_ev.rx_msg_sig),
      .match    (dup_match)
   );

   assign dup_det   = sig_mode && dup_match;
   assign long_det  = chan_ev.rx_msg_done && len_chk && (chan_ev.rx_msg_len > len_lim);
   assign short_det = chan_ev.rx_msg_done && !fcs_mode &&
                      (chan_ev.rx_msg_len < `SHORT_MIN_BYTES);

   ////////////////////////////////////////////////////////////////////////////
   // Mask gating onto the status flags

   always_comb begin
      set_bits = '0;
      set_bits[`ST_THR]  = sig_mode && chan_ev.thresh_cross && !msk_thr;
      set_bits[`ST_UP]   = sig_mode && chan_ev.count_up && !msk_up;
      set_bits[`ST_DN]   = sig_mode && chan_ev.count_down && !msk_dn;
      set_bits[`ST_DUP]  = dup_det && !msk_dup;
      set_bits[`ST_LINE] = (chan_ev.abort_change || chan_ev.idle_change || short_det) &&
                           !msk_line;
      // Long, check and alignment errors need both masks to go quiet
      set_bits[`ST_MSG]  = ((long_det || chan_ev.fcs_error || chan_ev.align_error) &&
                            (!msk_msg || !msk_eom)) ||
                           (chan_ev.abort && !msk_msg);
      set_bits[`ST_EOM]  = (chan_ev.rx_end || chan_ev.tx_end) && !msk_eom;
      set_bits[`ST_FIFO] = (chan_ev.tx_underflow || chan_ev.rx_overflow) && !msk_fifo;
      set_bits[`ST_OWN]  = (chan_ev.rx_own_missing || chan_ev.tx_own_missing) &&
                           !msk_fifo;
   end

   assign wr_hit   = mapped(aw_addr_q);
   assign do_write = aw_hold_q && w_hold_q && !rsp_q.bvalid;
   assign clr_word = merge_strb(32'h0000_0000, w_data_q, w_strb_q);
   assign en_word  = merge_strb({23'h00_0000, enable_q}, w_data_q, w_strb_q);
   assign clr_bits = (do_write && wr_hit && aw_addr_q[7:0] == `OFS_CLEAR) ?
                     clr_word[`ST_W-1:0] : '0;

   sticky_bank #(.W(`ST_W)) u_status (
      .ref_clk (ref_clk),
      .srst    (srst),
      .set     (set_bits),
      .clr     (clr_bits),
      .flags_q (status_q)
   );

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & enable_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-message controls, registered

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl_q <= '0;
      end else begin
         ctrl_q.protocol        <= proto;
         ctrl_q.signalling_mode <= sig_mode;
         ctrl_q.crc32_sel       <= (proto == `PROTO_FCS32);
         ctrl_q.rx_store_fcs    <= fcs_mode;
         ctrl_q.tx_append_fcs   <= !fcs_mode;
         ctrl_q.short_check_en  <= !fcs_mode;
         ctrl_q.len_check_en    <= len_chk;
         ctrl_q.len_limit       <= len_lim;
         ctrl_q.rx_discard      <= dup_det;
         ctrl_q.rx_len_error    <= long_det;
         ctrl_q.rx_short_error  <= short_det;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         discard_cnt_q <= 16'h0000;
      end else if (dup_det) begin
         discard_cnt_q <= discard_cnt_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data in either order

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         aw_hold_q <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
      end else if (axil_req.awvalid && rsp_q.awready) begin
         aw_hold_q <= 1'b1;
         aw_addr_q <= axil_req.awaddr;
      end else if (do_write) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         w_hold_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (axil_req.wvalid && rsp_q.wready) begin
         w_hold_q <= 1'b1;
         w_data_q <= axil_req.wdata;
         w_strb_q <= axil_req.wstrb;
      end else if (do_write) begin
         w_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg_q    <= `CFG_RST;
         limit_q  <= `LIMIT_RST;
         enable_q <= `ENABLE_RST;
      end else if (do_write && wr_hit) begin
         case (aw_addr_q[7:0])
            `OFS_CFG:    cfg_q    <= merge_strb(cfg_q, w_data_q, w_strb_q) & `CFG_WMASK;
            `OFS_LIMIT:  limit_q  <= merge_strb(limit_q, w_data_q, w_strb_q);
            `OFS_ENABLE: enable_q <= en_word[`ST_W-1:0];
            default:     enable_q <= enable_q;
         endcase
      end
   end

   // Readies drop once a beat is held and return only after the response is taken
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rsp_q.awready <= 1'b1;
         rsp_q.wready  <= 1'b1;
         rsp_q.bvalid  <= 1'b0;
         rsp_q.bresp   <= `RESP_OKAY;
         rsp_q.arready <= 1'b1;
         rsp_q.rvalid  <= 1'b0;
         rsp_q.rdata   <= 32'h0000_0000;
         rsp_q.rresp   <= `RESP_OKAY;
      end else begin
         if (axil_req.awvalid && rsp_q.awready) begin
            rsp_q.awready <= 1'b0;
         end
         if (axil_req.wvalid && rsp_q.wready) begin
            rsp_q.wready <= 1'b0;
         end
         if (do_write) begin
            rsp_q.bvalid <= 1'b1;
            rsp_q.bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rsp_q.bvalid && axil_req.bready) begin
            rsp_q.bvalid  <= 1'b0;
            rsp_q.awready <= 1'b1;
            rsp_q.wready  <= 1'b1;
         end
         // Read side lives here too so the response struct has a single driver
         if (axil_req.arvalid && rsp_q.arready) begin
            rsp_q.arready <= 1'b0;
            rsp_q.rvalid  <= 1'b1;
            rsp_q.rdata   <= rd_hit ? rd_data : 32'h0000_0000;
            rsp_q.rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rsp_q.rvalid && axil_req.rready) begin
            rsp_q.arready <= 1'b1;
            rsp_q.rvalid  <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path

   assign rd_hit = mapped(axil_req.araddr);

   always_comb begin
      rd_data = 32'h0000_0000;
      case (axil_req.araddr[7:0])
         `OFS_CFG:    rd_data = cfg_q;
         `OFS_LIMIT:  rd_data = limit_q;
         `OFS_STATUS: rd_data = {23'h00_0000, status_q};
         `OFS_ENABLE: rd_data = {23'h00_0000, enable_q};
         `OFS_STATE:  rd_data = {15'h0000, irq_q, discard_cnt_q};
         default:     rd_data = 32'h0000_0000;
      endcase
   end

   assign axil_rsp  = rsp_q;
   assign chan_ctrl = ctrl_q;
   assign irq       = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_len_second_sel: assert property (
      (chan_ev.rx_msg_done && len_sel == `SEL_SECOND &&
       chan_ev.rx_msg_len > limit_q[`LIM_SECOND_LSB +: 16]) |=> ctrl_q.rx_len_error)
      else $error("second length limit not applied");
   a_fcs_normal_mode: assert property (
      (!fcs_mode && $stable(cfg_q)) |=> (ctrl_q.tx_append_fcs && !ctrl_q.rx_store_fcs))
      else $error("normal check sequence mode wrong");
   a_fcs_store_mode: assert property (
      (fcs_mode && $stable(cfg_q)) |=> (!ctrl_q.tx_append_fcs && ctrl_q.rx_store_fcs))
      else $error("check sequence store mode wrong");
   a_short_off_nofcs: assert property (
      (fcs_mode && chan_ev.rx_msg_done) |=> !ctrl_q.rx_short_error)
      else $error("short detection active without check sequence");
   // The interrupt follows the enable of the cycle before, so a late enable write is no miss
   a_thresh_report: assert property (
      (sig_mode && chan_ev.thresh_cross && !msk_thr) |=>
      status_q[`ST_THR] ##1 (irq_q || !$past(enable_q[`ST_THR])))
      else $error("threshold event not reported");
   a_count_up_mask: assert property (
      (!status_q[`ST_UP] && chan_ev.count_up && msk_up && !clr_bits[`ST_UP]) |=>
      !status_q[`ST_UP] || $past(set_bits[`ST_UP]))
      else $error("masked count increment reported");
   a_dup_discard: assert property (
      (sig_mode && dup_match) |=> ctrl_q.rx_discard &&
      (status_q[`ST_DUP] == ($past(status_q[`ST_DUP]) || !$past(msk_dup)) ||
       $past(clr_bits[`ST_DUP])))
      else $error("duplicate not discarded or misreported");
   a_msg_err_pair: assert property (
      (!status_q[`ST_MSG] && msk_msg && msk_eom && chan_ev.fcs_error) |=> !status_q[`ST_MSG])
      else $error("check error reported with both masks set");
   a_msg_err_single: assert property (
      (chan_ev.align_error && msk_msg && !msk_eom) |=> status_q[`ST_MSG])
      else $error("alignment error not reported");
   a_eom_report: assert property (
      (chan_ev.tx_end && !msk_eom) |=> status_q[`ST_EOM])
      else $error("end of message not reported");
   a_own_report: assert property (
      (chan_ev.rx_own_missing && !msk_fifo) |=> status_q[`ST_OWN])
      else $error("ownership miss not reported");
   a_irq_level: assert property (
      (|(status_q & enable_q)) |=> irq_q)
      else $error("interrupt not raised for enabled flag");

endmodule

//--- verification/testbench.sv
// Self-checking testbench for the channel configuration and event masking block
`timescale 1ns/10ps
`include "chan_cfg_defs.svh"
module testbench;
   logic                     ref_clk;
   logic                     srst;
   chan_cfg_pkg::axil_req_s  req;
   chan_cfg_pkg::axil_rsp_s  rsp;
   chan_cfg_pkg::chan_ev_s   ev;
   chan_cfg_pkg::chan_ctrl_s chan_ctrl;
   logic                     irq;
   logic [31:0]              d, cfg, en, lim;
   logic [15:0]              l;
   logic [1:0]               r, br;
   logic [8:0]               st;
   int                       i, j, error_cnt, checks;
   integer                   seed;

   channel_event_mask_config channel_event_mask_config_inst (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .axil_req  (req),
      .axil_rsp  (rsp),
      .chan_ev   (ev),
      .chan_ctrl (chan_ctrl),
      .irq       (irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task test_done;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task hang;
      error_cnt++;
      $display("ERROR bus answer expected within 50 cycles seen none");
      test_done();
   endtask

   // Readiness is sampled at the falling edge, where it is settled for the next rising edge
   task wr(input logic [7:0] a, input logic [31:0] v);
      bit aw_t, w_t, b_t;
      @(posedge ref_clk);
      req.awvalid <= 1'b1;
      req.awaddr  <= {24'h0, a};
      req.wvalid  <= 1'b1;
      req.wdata   <= v;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         aw_t = req.awvalid & rsp.awready;
         w_t  = req.wvalid & rsp.wready;
         b_t  = rsp.bvalid;
         br   = rsp.bresp;
         @(posedge ref_clk);
         if (aw_t)
            req.awvalid <= 1'b0;
         if (w_t)
            req.wvalid <= 1'b0;
         if (b_t) begin
            req.bready <= 1'b0;
            return;
         end
      end
      hang();
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
      bit ar_t, r_t;
      @(posedge ref_clk);
      req.arvalid <= 1'b1;
      req.araddr  <= {24'h0, a};
      req.rready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         ar_t = req.arvalid & rsp.arready;
         r_t  = rsp.rvalid;
         v    = rsp.rdata;
         rr   = rsp.rresp;
         @(posedge ref_clk);
         if (ar_t)
            req.arvalid <= 1'b0;
         if (r_t) begin
            req.rready <= 1'b0;
            return;
         end
      end
      hang();
   endtask

   // Events sit from bit 62 down in declaration order
   task pulse(input int k);
      @(posedge ref_clk);
      ev[62-k] <= 1'b1;
      @(posedge ref_clk);
      ev <= '0;
   endtask

   task msg(input logic [15:0] n, input logic [31:0] s);
      @(posedge ref_clk);
      ev.rx_msg_done <= 1'b1;
      ev.rx_msg_len  <= n;
      ev.rx_msg_sig  <= s;
      @(posedge ref_clk);
      ev <= '0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [8:0] exp_st(int k, logic [31:0] c);
      int  sb[14] = '{0, 1, 2, 4, 4, 5, 5, 5, 6, 6, 7, 7, 8, 8};
      int  mb[14] = '{8, 7, 6, 4, 4, 3, 3, 3, 2, 2, 1, 1, 1, 1};
      logic m;
      m = c[mb[k]];
      if (k == 5 || k == 6)
         m = c[3] & c[2];
      if (k < 3 && c[14:12] != `PROTO_SIGNAL)
         m = 1'b1;
      return m ? 9'h000 : 9'h001 << sb[k];
   endfunction

   function automatic logic [15:0] exp_lim(logic [31:0] c, logic [31:0] t);
      case (c[11:10])
         2'h1: return t[15:0];
         2'h2: return t[31:16];
         default: return 16'hffff;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      seed = 32'h6598;
      srst = 1'b1;
      req  = '0;
      ev   = '0;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      rd(`OFS_CFG, d, r);
      chk("cfg reset", `CFG_RST, d);
      rd(`OFS_LIMIT, d, r);
      chk("limit reset", `LIMIT_RST, d);
      rd(`OFS_STATUS, d, r);
      chk("status reset", 32'h0, d);
      rd(8'h18, d, r);
      chk("unmapped resp", `RESP_SLVERR, r);
      wr(8'h18, 32'hffff_ffff);
      chk("unmapped wr resp", `RESP_SLVERR, br);
      rd(`OFS_CFG, d, r);
      chk("cfg after unmapped", `CFG_RST, d);
      $display("reset test done");
      // Small limits so random lengths land on both sides of them
      lim = $random(seed) & 32'h001f001f;
      wr(`OFS_LIMIT, lim);
      for (i = 0; i < 56; i++) begin
         cfg = $random(seed) & `CFG_WMASK;
         // Random protocol codes rarely hit signalling mode, so force it on every third pass
         if (i % 3 == 0)
            cfg[14:12] = 3'h1;
         en  = $random(seed);
         wr(`OFS_CLEAR, 32'h1ff);
         wr(`OFS_CFG, cfg);
         wr(`OFS_ENABLE, en);
         chk("protocol", cfg[14:12], chan_ctrl.protocol);
         chk("signalling", cfg[14:12] == 3'h1, chan_ctrl.signalling_mode);
         chk("crc32", cfg[14:12] == 3'h3, chan_ctrl.crc32_sel);
         chk("len check", cfg[11:10] == 2'h1 || cfg[11:10] == 2'h2, chan_ctrl.len_check_en);
         chk("store fcs", cfg[9], chan_ctrl.rx_store_fcs);
         chk("append fcs", !cfg[9], chan_ctrl.tx_append_fcs);
         chk("short en", !cfg[9], chan_ctrl.short_check_en);
         chk("limit", exp_lim(cfg, lim), chan_ctrl.len_limit);
         pulse(i % 14);
         st = exp_st(i % 14, cfg);
         rd(`OFS_STATUS, d, r);
         chk("status", st, d);
         chk("irq", |(st & en[8:0]), irq);
         l = (i < 8) ? 16'(i) : 16'($random(seed)) & 16'h001f;
         msg(l, $random(seed));
         chk("long", l > exp_lim(cfg, lim), chan_ctrl.rx_len_error);
         chk("short", !cfg[9] && l < 16'h4, chan_ctrl.rx_short_error);
      end
      $display("event and config test done");
      for (j = 0; j < 2; j++) begin
         wr(`OFS_CLEAR, 32'h1ff);
         wr(`OFS_CFG, 32'h1000 | (j << 5));
         d = $random(seed);
         msg(16'h8, d);
         msg(16'h8, d);
         chk("discard", 1'b1, chan_ctrl.rx_discard);
         rd(`OFS_STATUS, d, r);
         chk("dup status", j == 0, d[`ST_DUP]);
      end
      rd(`OFS_STATE, d, r);
      chk("discard count", 32'h2, {16'h0000, d[15:0]});
      $display("duplicate test done");
      test_done();
   end
endmodule
